/* core/pbm_cfg.svh */
`ifndef PBM_CFG_SVH
`define PBM_CFG_SVH

// ****************************************************************
// register addresses
// ****************************************************************
`define PBM_ADDR_CTRL    5'h00
`define PBM_ADDR_STAT    5'h01
`define PBM_ADDR_INDCMD  5'h0d
`define PBM_ADDR_INDDATA 5'h0e

// ****************************************************************
// basic_control fields
// ****************************************************************
`define PBM_CTRL_RESET   15
`define PBM_CTRL_LOOP    14
`define PBM_CTRL_PDOWN   11
`define PBM_CTRL_ISOL    10
`define PBM_CTRL_SPEED   6
`define PBM_CTRL_RESVAL  16'h0040

// ****************************************************************
// basic_status fields
// ****************************************************************
`define PBM_STAT_EXTST   8
`define PBM_STAT_PRESUP  6
`define PBM_STAT_LINK    2
`define PBM_STAT_EXTCAP  0
`define PBM_STAT_RESVAL  16'h0141

// ****************************************************************
// indirect access fields
// ****************************************************************
`define PBM_IND_CMD_HI   15
`define PBM_IND_CMD_LO   14
`define PBM_IND_DEV_HI   4
`define PBM_IND_MMD_LO   12
`define PBM_IND_OFF_MASK 16'h0fff

// ****************************************************************
// management frame fields
// ****************************************************************
`define PBM_OP_READ      2'b10
`define PBM_OP_WRITE     2'b01
`define PBM_CNT_OP       4'h1
`define PBM_CNT_FIELD    4'h4
`define PBM_CNT_TA       4'h1
`define PBM_CNT_DATA     4'hf

`endif

/* core/pbm_pkg.sv */
package pbm_pkg;

  typedef enum logic [2:0]
  {
    PBM_IDLE  = 3'b000,
    PBM_START = 3'b001,
    PBM_OPC   = 3'b010,
    PBM_PHYA  = 3'b011,
    PBM_REGA  = 3'b100,
    PBM_TURN  = 3'b101,
    PBM_DATA  = 3'b110
  } pbm_state_t;

  typedef enum logic [1:0]
  {
    PBM_CMD_ADDR   = 2'b00,
    PBM_CMD_NOINC  = 2'b01,
    PBM_CMD_INCRW  = 2'b10,
    PBM_CMD_INCWR  = 2'b11
  } pbm_cmd_t;

  typedef struct packed
  {
    logic digitalReset;
    logic loopbackEn;
    logic powerDown;
    logic isolateEn;
  } pbm_ctrl_t;

  typedef struct packed
  {
    logic       mdc;
    logic       mdioIn;
    logic       linkUp;
    logic       powerDownPin;
    logic [4:0] phyAddr;
  } pbm_pins_t;

endpackage

/* core/pbm_mgmt_regs.sv */
`timescale 1ns/100ps
`include "pbm_cfg.svh"

// Function
// - top nibble names mmd space, ignored
// - control bit 15 resets basic registers
// - control bit 14 enables mac loopback
// - control bit 11 powers down, shows pin
// - control bit 10 isolates mac, resets zero
// - control bit 6 reads one, 1000 speed
// - control register resets to 40h
// - status bit 8 reads one
// - status bit 6 one, preambleless frames decoded
// - status bit 2 shows link state
// - status bit 0 reads one
// - status register resets to 141h
// - indirect command selects address or data phase
module pbm_mgmt_regs
(
  // clock and reset
  input  wire logic          clock,
  input  wire logic          reset,
  // pins
  input  wire pbm_pkg::pbm_pins_t pins,
  output      logic          mdioOut,
  output      logic          mdioOe,
  // device controls
  output      pbm_pkg::pbm_ctrl_t ctrl,
  output      logic [15:0]   mmdAddr,
  output      logic [4:0]    mmdDev
);
  import pbm_pkg::*;

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  pbm_pins_t   syncA_q;
  pbm_pins_t   syncB_q;
  logic        mdcPrev_q;
  logic        mdcRise;
  logic        mdcFall;

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      syncA_q   <= '0;
      syncB_q   <= '0;
      mdcPrev_q <= 1'b0;
    end
    else
    begin
      syncA_q   <= pins;
      syncB_q   <= syncA_q;
      mdcPrev_q <= syncB_q.mdc;
    end
  end

  assign mdcRise = syncB_q.mdc & ~mdcPrev_q;
  assign mdcFall = ~syncB_q.mdc & mdcPrev_q;

  // ****************************************************************
  // frame decoder
  // ****************************************************************
  pbm_state_t  state_q;
  logic [3:0]  cnt_q;
  logic [1:0]  op_q;
  logic [4:0]  phy_q;
  logic [4:0]  reg_q;
  logic [15:0] shift_q;
  logic        hit;
  logic        wrDone;
  logic        rdTake;
  logic        bitIn;

  assign bitIn = syncB_q.mdioIn;
  assign hit   = (phy_q == syncB_q.phyAddr);
  assign wrDone = mdcRise && state_q == PBM_DATA && cnt_q == `PBM_CNT_DATA
                  && op_q == `PBM_OP_WRITE && hit;
  assign rdTake = mdcRise && state_q == PBM_REGA
                  && cnt_q == `PBM_CNT_FIELD && op_q == `PBM_OP_READ
                  && hit;

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      state_q <= PBM_IDLE;
      cnt_q   <= 4'h0;
      op_q    <= 2'b00;
      phy_q   <= 5'h00;
      reg_q   <= 5'h00;
      shift_q <= 16'h0000;
    end
    else if (mdcRise)
    begin
      unique case (state_q)
        // a zero after ones or after nothing starts a frame
        PBM_IDLE:
        begin
          if (!bitIn)
            state_q <= PBM_START;
        end
        PBM_START:
        begin
          state_q <= bitIn ? PBM_OPC : PBM_IDLE;
          cnt_q   <= 4'h0;
        end
        PBM_OPC:
        begin
          op_q  <= {op_q[0], bitIn};
          cnt_q <= cnt_q + 4'h1;
          if (cnt_q == `PBM_CNT_OP)
          begin
            state_q <= PBM_PHYA;
            cnt_q   <= 4'h0;
          end
        end
        PBM_PHYA:
        begin
          phy_q <= {phy_q[3:0], bitIn};
          cnt_q <= cnt_q + 4'h1;
          if (cnt_q == `PBM_CNT_FIELD)
          begin
            state_q <= PBM_REGA;
            cnt_q   <= 4'h0;
          end
        end
        PBM_REGA:
        begin
          reg_q <= {reg_q[3:0], bitIn};
          cnt_q <= cnt_q + 4'h1;
          if (cnt_q == `PBM_CNT_FIELD)
          begin
            state_q <= PBM_TURN;
            cnt_q   <= 4'h0;
            shift_q <= rdMux({reg_q[3:0], bitIn});
          end
        end
        PBM_TURN:
        begin
          cnt_q <= cnt_q + 4'h1;
          if (cnt_q == `PBM_CNT_TA)
          begin
            state_q <= PBM_DATA;
            cnt_q   <= 4'h0;
          end
        end
        PBM_DATA:
        begin
          cnt_q <= cnt_q + 4'h1;
          if (op_q == `PBM_OP_WRITE)
            shift_q <= {shift_q[14:0], bitIn};
          if (cnt_q == `PBM_CNT_DATA)
            state_q <= PBM_IDLE;
        end
        default:
          state_q <= PBM_IDLE;
      endcase
    end
  end

  // ****************************************************************
  // read driver, changes on falling mdc
  // ****************************************************************
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      mdioOut <= 1'b0;
      mdioOe  <= 1'b0;
    end
    else if (mdcFall)
    begin
      if (op_q == `PBM_OP_READ && hit && state_q == PBM_TURN
          && cnt_q == `PBM_CNT_TA)
      begin
        mdioOut <= 1'b0;
        mdioOe  <= 1'b1;
      end
      else if (op_q == `PBM_OP_READ && hit && state_q == PBM_DATA)
      begin
        mdioOut <= shift_q[4'hf - cnt_q];
        mdioOe  <= 1'b1;
      end
      else
      begin
        mdioOut <= 1'b0;
        mdioOe  <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  logic        loop_q;
  logic        pdown_q;
  logic        isol_q;
  logic        link_q;
  pbm_cmd_t    cmd_q;
  logic [4:0]  dev_q;
  logic [15:0] addr_q;
  logic        softRst;
  logic [15:0] wd;

  assign wd      = {shift_q[14:0], bitIn};
  assign softRst = wrDone && reg_q == `PBM_ADDR_CTRL
                   && wd[`PBM_CTRL_RESET];

  function automatic logic [15:0] rdMux(input logic [4:0] a);
    logic [15:0] v;
    v = 16'h0000;
    unique case (a)
      `PBM_ADDR_CTRL:
      begin
        v[`PBM_CTRL_LOOP]  = loop_q;
        v[`PBM_CTRL_PDOWN] = pdown_q | syncB_q.powerDownPin;
        v[`PBM_CTRL_ISOL]  = isol_q;
        v[`PBM_CTRL_SPEED] = 1'b1;
      end
      `PBM_ADDR_STAT:
      begin
        v[`PBM_STAT_EXTST]  = 1'b1;
        v[`PBM_STAT_PRESUP] = 1'b1;
        v[`PBM_STAT_LINK]   = link_q;
        v[`PBM_STAT_EXTCAP] = 1'b1;
      end
      `PBM_ADDR_INDCMD:
        v = {cmd_q, 9'h000, dev_q};
      `PBM_ADDR_INDDATA:
        v = (cmd_q == PBM_CMD_ADDR) ? addr_q : 16'h0000;
      default:
        v = 16'h0000;
    endcase
    return v;
  endfunction

  // control bits, reset value 40h with speed bit fixed
  always_ff @(posedge clock)
  begin
    if (reset || softRst)
    begin
      loop_q  <= 1'b0;
      pdown_q <= 1'b0;
      isol_q  <= 1'b0;
    end
    else if (wrDone && reg_q == `PBM_ADDR_CTRL)
    begin
      loop_q  <= wd[`PBM_CTRL_LOOP];
      pdown_q <= wd[`PBM_CTRL_PDOWN];
      isol_q  <= wd[`PBM_CTRL_ISOL];
    end
  end

  // link state, status resets to 141h
  always_ff @(posedge clock)
  begin
    if (reset || softRst)
      link_q <= 1'b0;
    else
      link_q <= syncB_q.linkUp;
  end

  // indirect access command and address
  always_ff @(posedge clock)
  begin
    if (reset || softRst)
    begin
      cmd_q  <= PBM_CMD_ADDR;
      dev_q  <= 5'h00;
      addr_q <= 16'h0000;
    end
    else if (wrDone && reg_q == `PBM_ADDR_INDCMD)
    begin
      cmd_q <= pbm_cmd_t'(wd[`PBM_IND_CMD_HI:`PBM_IND_CMD_LO]);
      dev_q <= wd[`PBM_IND_DEV_HI:0];
    end
    else if (wrDone && reg_q == `PBM_ADDR_INDDATA)
    begin
      if (cmd_q == PBM_CMD_ADDR)
        addr_q <= wd & `PBM_IND_OFF_MASK;
      else if (cmd_q != PBM_CMD_NOINC)
        addr_q <= addr_q + 16'h0001;
    end
    else if (rdTake && {reg_q[3:0], bitIn} == `PBM_ADDR_INDDATA
             && cmd_q == PBM_CMD_INCRW)
      addr_q <= addr_q + 16'h0001;
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      ctrl    <= '0;
      mmdAddr <= 16'h0000;
      mmdDev  <= 5'h00;
    end
    else
    begin
      ctrl.digitalReset <= softRst;
      ctrl.loopbackEn   <= loop_q;
      ctrl.powerDown    <= pdown_q | syncB_q.powerDownPin;
      ctrl.isolateEn    <= isol_q;
      mmdAddr           <= addr_q;
      mmdDev            <= dev_q;
    end
  end

endmodule // pbm_mgmt_regs

/* testbench/pbm_mgmt_regs_monitor.sv */
`timescale 1ns/100ps
module pbm_mgmt_regs_monitor
(
  // clock and reset
  input wire logic               clock,
  input wire logic               reset,
  // device ports
  input wire pbm_pkg::pbm_pins_t pins,
  input wire logic               mdioOut,
  input wire logic               mdioOe,
  input wire pbm_pkg::pbm_ctrl_t ctrl,
  input wire logic [15:0]        mmdAddr,
  input wire logic [4:0]         mmdDev
);
  import pbm_pkg::*;
  logic [3:0] idleCnt;

  // cycles since mdc last moved
  always_ff @(posedge clock)
  begin
    if (reset || $changed(pins.mdc))
      idleCnt <= 4'h0;
    else if (idleCnt != 4'hf)
      idleCnt <= idleCnt + 4'h1;
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  sequence pinHeld;
    $rose(pins.powerDownPin) ##1 pins.powerDownPin [*6];
  endsequence
  sequence turnDrive;
    !mdioOut ##1 mdioOe [*8];
  endsequence

  a_reset_zero:
    assert property ($fell(reset) |-> ctrl == '0 && !mdioOe && mmdAddr == 0)
    else $error("outputs not clear after reset");
  a_top_nibble:
    assert property (mmdAddr[15:12] == 4'h0)
    else $error("mmd space nibble kept");
  a_pulse_single:
    assert property (ctrl.digitalReset |=> !ctrl.digitalReset)
    else $error("soft reset pulse too long");
  a_soft_clear:
    assert property (ctrl.digitalReset |-> ##[0:2]
      (!ctrl.loopbackEn && !ctrl.isolateEn && mmdAddr == 0 && mmdDev == 0))
    else $error("soft reset left state");
  a_pin_power:
    assert property (pinHeld |-> ctrl.powerDown)
    else $error("power-down pin not shown");
  a_turn_zero:
    assert property ($rose(mdioOe) |-> turnDrive)
    else $error("bad turnaround drive");
  a_drive_mdc:
    assert property ($changed(mdioOe) |-> !pins.mdc)
    else $error("drive changed while mdc high");
  a_idle_quiet:
    assert property (idleCnt > 4'h5 |-> !mdioOe &&
      $stable({ctrl.loopbackEn, ctrl.isolateEn, mmdAddr, mmdDev}))
    else $error("state moved while idle");
endmodule // pbm_mgmt_regs_monitor

bind pbm_mgmt_regs pbm_mgmt_regs_monitor u_pbm_mgmt_regs_monitor
(
  .clock   (clock),
  .reset   (reset),
  .pins    (pins),
  .mdioOut (mdioOut),
  .mdioOe  (mdioOe),
  .ctrl    (ctrl),
  .mmdAddr (mmdAddr),
  .mmdDev  (mmdDev)
);

/* testbench/pbm_mdio_master.sv */
`timescale 1ns/100ps
module pbm_mdio_master
(
  // clock
  input  wire logic clock,
  // device drive
  input  wire logic mdioOut,
  input  wire logic mdioOe,
  // management wire
  output      logic mdc,
  output      logic mdio
);
  logic drv = 1'b0;
  logic bitv = 1'b1;

  // pull-up holds the wire high when released
  assign mdio = mdioOe ? mdioOut : (drv ? bitv : 1'b1);
  initial mdc = 1'b0;

  // one frame with an optional preamble of ones, mdc at 10 clocks a bit
  task automatic frame(input logic [5:0] pre, input logic [1:0] op,
    input logic [4:0] pa, ra,
    input logic [15:0] wd, output logic [15:0] q);
    logic [31:0] f;
    f = {2'b01, op, pa, ra, 2'b10, wd};
    q = 16'h0;
    for (int k = 0; k < pre; k++)
    begin
      drv  = 1'b1;
      bitv = 1'b1;
      repeat (5) @(negedge clock);
      mdc = 1'b1;
      repeat (5) @(negedge clock);
      mdc = 1'b0;
    end
    for (int i = 31; i >= 0; i--)
    begin
      drv  = op == 2'b01 || i > 17;
      bitv = f[i];
      repeat (5) @(negedge clock);
      mdc = 1'b1;
      q   = {q[14:0], mdio};
      repeat (5) @(negedge clock);
      mdc = 1'b0;
    end
    drv = 1'b0;
    // device lets go of the wire a few clocks after the last fall
    repeat (4) @(negedge clock);
  endtask
endmodule // pbm_mdio_master

/* testbench/pbm_mgmt_regs_test.sv */
`timescale 1ns/100ps
module pbm_mgmt_regs_test;
  import pbm_pkg::*;
  localparam logic [4:0] PHY_ADDR = 5'h0b;
  logic        clock;
  logic        reset;
  logic        mdc;
  logic        mdio;
  logic        linkUp;
  logic        pdPin;
  logic [4:0]  pa;
  logic [5:0]  pre;
  logic        mdioOut;
  logic        mdioOe;
  pbm_ctrl_t   ctrl;
  logic [15:0] mmdAddr;
  logic [4:0]  mmdDev;
  logic [15:0] w;
  logic [15:0] a;
  int          numErrors;
  int          cmpCount;

  pbm_mgmt_regs u_pbm_mgmt_regs
  (
    .clock   (clock),
    .reset   (reset),
    .pins    ({mdc, mdio, linkUp, pdPin, PHY_ADDR}),
    .mdioOut (mdioOut),
    .mdioOe  (mdioOe),
    .ctrl    (ctrl),
    .mmdAddr (mmdAddr),
    .mmdDev  (mmdDev)
  );

  pbm_mdio_master u_pbm_mdio_master
  (
    .clock   (clock),
    .mdioOut (mdioOut),
    .mdioOe  (mdioOe),
    .mdc     (mdc),
    .mdio    (mdio)
  );

  initial
  begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmpCount++;
    if (got !== exp)
    begin
      numErrors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [4:0] r, input logic [15:0] d);
    logic [15:0] q;
    u_pbm_mdio_master.frame(pre, 2'b01, pa, r, d, q);
  endtask

  task automatic rd(input logic [4:0] r, input logic [15:0] e);
    logic [15:0] q;
    u_pbm_mdio_master.frame(pre, 2'b10, pa, r, 16'h0, q);
    chk(q, e);
  endtask

  function automatic logic [15:0] expCtrl(input logic [15:0] d, input logic p);
    return (d & 16'h4c00) | 16'h0040 | {4'h0, p, 11'h0};
  endfunction

  task conclude;
    if (numErrors == 0 && cmpCount > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial
  begin
    repeat (40000) @(posedge clock);
    numErrors++;
    conclude();
  end

  initial
  begin
    reset = 1'b1;
    linkUp = 1'b0;
    pdPin = 1'b0;
    pa = PHY_ADDR;
    pre = 6'h00;
    numErrors = 0;
    cmpCount = 0;
    void'($urandom(3));
    repeat (8) @(negedge clock);
    reset = 1'b0;
    repeat (4) @(negedge clock);
    rd(5'h00, 16'h0040);
    rd(5'h01, 16'h0141);
    rd(5'h1f, 16'h0000);
    // random writes with every loopback, isolate and power-down pin combination
    for (int i = 0; i < 8; i++)
    begin
      w = $urandom;
      w[15] = 1'b0;
      w[14] = i[1];
      w[10] = i[2];
      pdPin = i[0];
      linkUp = i[0] ^ i[2];
      wr(5'h00, w);
      wr(5'h01, ~w);
      rd(5'h00, expCtrl(w, pdPin));
      rd(5'h01, 16'h0141 | {13'h0, linkUp, 2'h0});
      chk({12'h0, ctrl}, {13'h0, w[14], w[11] | pdPin, w[10]});
    end
    // another phy address is ignored
    wr(5'h00, 16'h4400);
    pa = PHY_ADDR ^ 5'h01;
    wr(5'h00, 16'h0800);
    rd(5'h00, 16'hffff);
    pa = PHY_ADDR;
    rd(5'h00, expCtrl(16'h4400, pdPin));
    // frames led by a preamble of ones decode as well
    pre = 6'h20;
    wr(5'h00, 16'h4c00);
    rd(5'h00, expCtrl(16'h4c00, pdPin));
    pre = 6'h00;
    // indirect address phase, then each data command
    wr(5'h0d, 16'h0007);
    wr(5'h0e, 16'h3abc);
    chk(mmdAddr, 16'h0abc);
    chk({11'h0, mmdDev}, 16'h0007);
    rd(5'h0e, 16'h0abc);
    a = 16'h0abc;
    for (int c = 1; c < 4; c++)
    begin
      wr(5'h0d, {c[1:0], 14'h0007});
      wr(5'h0e, w);
      a = a + 16'(c != 1);
      chk(mmdAddr, a);
      rd(5'h0e, 16'h0000);
      a = a + 16'(c == 2);
      chk(mmdAddr, a);
    end
    // soft reset
    pdPin = 1'b0;
    wr(5'h00, 16'h8000);
    rd(5'h00, 16'h0040);
    rd(5'h0d, 16'h0000);
    chk(mmdAddr, 16'h0000);
    conclude();
  end
endmodule // pbm_mgmt_regs_test
